// [rtl/stkseq_core.sv]
// Purpose: Sequences stack pointer moves and stack accesses
// Assumes: Memory side answers each access with mem_done
// Notes: OPSZ_VARIANT 0 narrow legacy, 1 operand sized
`timescale 1ns/100ps
`default_nettype none
module stkseq_core
    import stkseq_pkg::*;
#(
    parameter bit OPSZ_VARIANT = 1'b1,
    parameter bit BRANCH_FIRST = 1'b1
)(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Request from instruction control
    input wire logic req_valid,
    input wire stkseq_req_t req,
    output logic req_ready,
    // Stack pointer
    input wire logic [31:0] sp_in,
    input wire logic [31:0] seg_limit,
    output logic [31:0] stack_pointer,
    // Branch check from segment logic
    input wire logic br_chk_done,
    input wire logic br_limit_viol,
    input wire logic br_rights_viol,
    // Memory side
    output logic mem_valid,
    output stkseq_mem_t mem_req,
    input wire logic mem_done,
    input wire logic [31:0] mem_rdata,
    input wire logic page_bad_hi,
    // Results
    output logic done,
    output logic stack_fault,
    output logic branch_fault,
    output logic [31:0] pop_data
);
    stkseq_state_t st_r, st_nxt;
    stkseq_req_t req_r;
    logic [31:0] sp_r, sp_start_r, pop_r;
    logic br_ok_r, br_seen_r, fault_r, bfault_r;

    wire logic [3:0] opsz;
    wire logic [31:0] opsz_w;
    wire logic is_push, is_pop, is_call;
    wire logic [3:0] acc_size;
    wire logic [31:0] acc_addr, push_sp, wdata;
    wire logic wrap_case, lim_fault, lim_hi;
    wire logic br_fault_now;
    assign opsz = (req_r.opsz32 || (req_r.op == STKSEQ_OP_ERR_PUSH && req_r.stack32))
        ? STKSEQ_SZ4 : STKSEQ_SZ2;
    assign opsz_w = {28'h0, opsz};
    assign is_call = (req_r.op == STKSEQ_OP_FAR_CALL);
    assign is_push = (req_r.op == STKSEQ_OP_SEL_PUSH) || (req_r.op == STKSEQ_OP_ERR_PUSH) || is_call;
    assign is_pop = !is_push;
    assign push_sp = sp_r - opsz_w;
    // Access width per variant; only selector and error accesses are narrowed
    assign acc_size = (is_call || req_r.op == STKSEQ_OP_POP_MEM) ? opsz
        : (OPSZ_VARIANT ? opsz : STKSEQ_SZ2);
    // Pop to memory wrap on a 16-bit stack
    assign wrap_case = (req_r.op == STKSEQ_OP_POP_MEM) && !req_r.stack32 &&
        (sp_r == (req_r.opsz32 ? STKSEQ_SP_POP32_WRAP : STKSEQ_SP_POP16_WRAP));
    // Address: push uses lowered pointer, pop current, second memory step of pop-mem
    assign acc_addr = (st_r == STKSEQ_ACC1 && req_r.op == STKSEQ_OP_POP_MEM)
        ? (wrap_case ? (OPSZ_VARIANT ? STKSEQ_SEG64K_OFS : STKSEQ_ZERO) + req_r.ea_extra
                     : sp_r + opsz_w + req_r.ea_extra)
        : (is_push ? push_sp : sp_r);
    assign wdata = (st_r == STKSEQ_ACC1 && req_r.op == STKSEQ_OP_POP_MEM) ? pop_r
        : (st_r == STKSEQ_ACC1) ? req_r.data1
        : {STKSEQ_HI_ZERO, req_r.data0[15:0]} | (is_call ? {req_r.data0[31:16], 16'h0} : 32'h0);
    assign br_fault_now = br_chk_done && (br_limit_viol || br_rights_viol);

    stkseq_limit_chk u_lim (
        .addr(acc_addr),
        .size(acc_size),
        .limit(seg_limit),
        .page_bad_hi(page_bad_hi),
        .fault_any(lim_fault),
        .fault_hi(lim_hi)
    );

    wire logic acc_phase;
    wire logic wrap_fault;
    wire logic acc_fault;
    assign acc_phase = (st_r == STKSEQ_ACC0) || (st_r == STKSEQ_ACC1);
    // Wide variant faults on a wrap pop in real mode or 64K segment
    assign wrap_fault = OPSZ_VARIANT && wrap_case && (st_r == STKSEQ_ACC1) &&
        (req_r.real_mode || seg_limit <= STKSEQ_SEG64K_LIMIT);
    // Narrow variant drops the whole fault when the upper half faults, as on a four-byte pop-mem access
    assign acc_fault = acc_phase && !is_call && (OPSZ_VARIANT ? lim_fault : (lim_fault && !lim_hi));

    assign req_ready = (st_r == STKSEQ_IDLE);
    assign mem_valid = acc_phase && !acc_fault && !wrap_fault &&
        !(st_r == STKSEQ_ACC1 && req_r.op != STKSEQ_OP_POP_MEM && !is_call);
    assign mem_req.write = is_push || (st_r == STKSEQ_ACC1);
    assign mem_req.addr = acc_addr;
    assign mem_req.size = acc_size;
    assign mem_req.wdata = wdata;
    assign stack_pointer = sp_r;
    assign done = (st_r == STKSEQ_DONE);
    assign stack_fault = fault_r;
    assign branch_fault = bfault_r;
    assign pop_data = pop_r;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            STKSEQ_IDLE: begin
                if (req_valid) begin
                    st_nxt = (req.op == STKSEQ_OP_FAR_CALL && BRANCH_FIRST) ? STKSEQ_BRCHK : STKSEQ_ACC0;
                end
            end
            STKSEQ_BRCHK: begin
                if (br_chk_done) begin
                    st_nxt = br_fault_now ? STKSEQ_DONE : STKSEQ_ACC0;
                end
            end
            STKSEQ_ACC0: begin
                if (acc_fault || br_fault_now && is_call && !BRANCH_FIRST) begin
                    st_nxt = STKSEQ_DONE;
                end else if (mem_done) begin
                    st_nxt = (is_call || req_r.op == STKSEQ_OP_POP_MEM) ? STKSEQ_ACC1 : STKSEQ_DONE;
                end
            end
            STKSEQ_ACC1: begin
                if (acc_fault || wrap_fault || (br_fault_now && is_call && !BRANCH_FIRST)) begin
                    st_nxt = STKSEQ_DONE;
                end else if (mem_done) begin
                    st_nxt = (is_call && !BRANCH_FIRST && !br_ok_r) ? STKSEQ_BRCHK : STKSEQ_DONE;
                end
            end
            STKSEQ_DONE: st_nxt = STKSEQ_IDLE;
            default: st_nxt = STKSEQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= STKSEQ_IDLE;
            req_r <= '0;
            sp_r <= STKSEQ_ZERO;
            sp_start_r <= STKSEQ_ZERO;
            pop_r <= STKSEQ_ZERO;
            br_ok_r <= 1'b0;
            br_seen_r <= 1'b0;
            fault_r <= 1'b0;
            bfault_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (st_r == STKSEQ_IDLE && req_valid) begin
                req_r <= req;
                sp_r <= sp_in;
                sp_start_r <= sp_in;
                br_ok_r <= 1'b0;
                br_seen_r <= 1'b0;
                fault_r <= 1'b0;
                bfault_r <= 1'b0;
            end
            if (br_chk_done && (st_r != STKSEQ_IDLE) && is_call && !br_seen_r) begin
                br_seen_r <= 1'b1;
                br_ok_r <= !br_fault_now;
            end
            if (acc_fault || wrap_fault) begin
                fault_r <= 1'b1;
                sp_r <= sp_start_r;
            end else if (is_call && br_fault_now && st_r != STKSEQ_IDLE && st_r != STKSEQ_DONE) begin
                bfault_r <= 1'b1;
                sp_r <= sp_start_r;
            end else if (acc_phase && mem_done && mem_valid) begin
                if (is_push) begin
                    sp_r <= push_sp;
                end else if (st_r == STKSEQ_ACC0) begin
                    pop_r <= (acc_size == STKSEQ_SZ2) ? {16'h0, mem_rdata[15:0]} : mem_rdata;
                    if (req_r.op != STKSEQ_OP_POP_MEM) begin
                        sp_r <= req_r.stack32 ? sp_r + opsz_w
                            : {16'h0, sp_r[15:0] + opsz_w[15:0]};
                    end
                end else begin
                    sp_r <= req_r.stack32 ? sp_r + opsz_w : {16'h0, sp_r[15:0] + opsz_w[15:0]};
                end
            end
        end
    end

    // Assertions
    AST_POP_NARROW: assert property (@(posedge clock) disable iff (rst)
        (mem_valid && req_r.op == STKSEQ_OP_SEL_POP && !OPSZ_VARIANT) |-> mem_req.size == STKSEQ_SZ2)
        else $error("narrow pop not two bytes");
    AST_PUSH_SIZE: assert property (@(posedge clock) disable iff (rst)
        (mem_valid && req_r.op == STKSEQ_OP_SEL_PUSH) |-> mem_req.size == (OPSZ_VARIANT ? opsz : STKSEQ_SZ2))
        else $error("selector push size wrong");
    AST_PUSH_HI_ZERO: assert property (@(posedge clock) disable iff (rst)
        (mem_valid && req_r.op != STKSEQ_OP_FAR_CALL && is_push) |-> mem_req.wdata[31:16] == 16'h0)
        else $error("push high half not zero");
    AST_PUSH_SP: assert property (@(posedge clock) disable iff (rst)
        (mem_valid && mem_done && is_push && st_r == STKSEQ_ACC0 && !acc_fault && !br_fault_now)
        |=> sp_r == $past(sp_r) - $past(opsz_w))
        else $error("push did not lower pointer by operand size");
    AST_ERR_SP4: assert property (@(posedge clock) disable iff (rst)
        (mem_valid && req_r.op == STKSEQ_OP_ERR_PUSH && req_r.stack32) |-> mem_req.addr == sp_r - 32'h4)
        else $error("error push pointer not minus four");
    AST_NARROW_NO_HI: assert property (@(posedge clock) disable iff (rst)
        (!OPSZ_VARIANT && acc_phase && lim_hi && !lim_fault) |-> !acc_fault)
        else $error("narrow faulted on upper bytes");
    AST_BR_RESTORE: assert property (@(posedge clock) disable iff (rst)
        (is_call && br_fault_now && acc_phase) |=> sp_r == sp_start_r && bfault_r)
        else $error("pointer not restored on branch fault");
    AST_BR_FIRST: assert property (@(posedge clock) disable iff (rst)
        (BRANCH_FIRST && is_call && mem_valid) |-> br_ok_r)
        else $error("push before branch check");
    AST_WRAP_NARROW: assert property (@(posedge clock) disable iff (rst)
        (!OPSZ_VARIANT && wrap_case && st_r == STKSEQ_ACC1 && mem_valid) |-> mem_req.addr == req_r.ea_extra)
        else $error("wrap pop address wrong");
    AST_BR_CLASS: assert property (@(posedge clock) disable iff (rst)
        (br_chk_done && br_limit_viol && is_call && st_r == STKSEQ_BRCHK) |=> bfault_r)
        else $error("branch fault not flagged");

    // Width, address, pointer, fault, branch-order and handshake checks
    AST_POP_WIDE_SIZE: assert property (@(posedge clock) disable iff (rst)
        (OPSZ_VARIANT && mem_valid && req_r.op == STKSEQ_OP_SEL_POP) |-> mem_req.size == opsz)
        else $error("wide pop not operand sized");
    AST_POP_SP_STEP: assert property (@(posedge clock) disable iff (rst)
        (mem_valid && mem_done && req_r.op == STKSEQ_OP_SEL_POP && req_r.stack32)
        |=> sp_r == $past(sp_r) + $past(opsz_w))
        else $error("pop did not raise pointer by operand size");
    AST_SEL_PUSH_ADDR: assert property (@(posedge clock) disable iff (rst)
        (mem_valid && req_r.op == STKSEQ_OP_SEL_PUSH) |-> mem_req.addr == sp_r - opsz_w)
        else $error("selector push address wrong");
    AST_ERR_FULL: assert property (@(posedge clock) disable iff (rst)
        (OPSZ_VARIANT && mem_valid && req_r.op == STKSEQ_OP_ERR_PUSH && req_r.stack32)
        |-> mem_req.size == STKSEQ_SZ4)
        else $error("full error code not four bytes");
    AST_ERR_LEGACY: assert property (@(posedge clock) disable iff (rst)
        (!OPSZ_VARIANT && mem_valid && req_r.op == STKSEQ_OP_ERR_PUSH) |-> mem_req.size == STKSEQ_SZ2)
        else $error("legacy error code not two bytes");
    AST_WIDE_HI_FAULT: assert property (@(posedge clock) disable iff (rst)
        (OPSZ_VARIANT && acc_phase && !is_call && lim_hi) |-> !mem_valid)
        else $error("wide access ran past limit on upper bytes");
    AST_FAULT_RESTORE: assert property (@(posedge clock) disable iff (rst)
        (acc_phase && acc_fault) |=> sp_r == sp_start_r && fault_r)
        else $error("pointer not restored on stack fault");
    AST_WRAP_WIDE: assert property (@(posedge clock) disable iff (rst)
        (OPSZ_VARIANT && wrap_case && st_r == STKSEQ_ACC1 && mem_valid)
        |-> mem_req.addr == STKSEQ_SEG64K_OFS + req_r.ea_extra)
        else $error("wide wrap pop address wrong");
    AST_WRAP_FAULT: assert property (@(posedge clock) disable iff (rst)
        (OPSZ_VARIANT && wrap_case && st_r == STKSEQ_ACC1 &&
        (req_r.real_mode || seg_limit <= STKSEQ_SEG64K_LIMIT)) |-> !mem_valid)
        else $error("wide wrap pop wrote instead of faulting");
    AST_WRAP_SP: assert property (@(posedge clock) disable iff (rst)
        (wrap_case && st_r == STKSEQ_ACC1 && mem_valid && mem_done) |=> sp_r == STKSEQ_ZERO)
        else $error("wrap pop pointer not zero");
    AST_CALL_DATA: assert property (@(posedge clock) disable iff (rst)
        (is_call && mem_valid && st_r == STKSEQ_ACC0) |-> mem_req.wdata == req_r.data0)
        else $error("far call first push data wrong");
    AST_PUSH_FIRST: assert property (@(posedge clock) disable iff (rst)
        (!BRANCH_FIRST && is_call && st_r == STKSEQ_ACC0) |-> mem_valid)
        else $error("push-first call did not push");
    AST_BRCHK_NOMEM: assert property (@(posedge clock) disable iff (rst)
        (st_r == STKSEQ_BRCHK) |-> !mem_valid)
        else $error("access during branch check");
    AST_BR_RIGHTS: assert property (@(posedge clock) disable iff (rst)
        (br_chk_done && br_rights_viol && is_call && st_r == STKSEQ_BRCHK) |=> bfault_r)
        else $error("rights fault not flagged");
    AST_READY_IDLE: assert property (@(posedge clock) disable iff (rst)
        req_ready |-> !mem_valid)
        else $error("access while idle");
    AST_DONE_ONE: assert property (@(posedge clock) disable iff (rst)
        done |=> !done)
        else $error("done held too long");

    COV_CALL: cover property (@(posedge clock) disable iff (rst) is_call && done && !bfault_r);
    COV_PUSH: cover property (@(posedge clock) disable iff (rst) mem_valid && mem_done && is_push);
    COV_WRAP: cover property (@(posedge clock) disable iff (rst) wrap_case && st_r == STKSEQ_ACC1);
    COV_BRF: cover property (@(posedge clock) disable iff (rst) bfault_r && done);
    COV_SF: cover property (@(posedge clock) disable iff (rst) fault_r && done);
endmodule
`default_nettype wire

// [rtl/stkseq_pkg.sv]
// Purpose: Shared constants and types for the stack push/pop sequencer
// Assumes: 32-bit stack pointer, byte-addressed stack segment
// Notes: Variant selects legacy narrow access or operand-sized access
package stkseq_pkg;
    localparam logic [31:0] STKSEQ_SP_WRAP16 = 32'h0000_ffff;
    localparam logic [31:0] STKSEQ_SP_POP32_WRAP = 32'h0000_fffc;
    localparam logic [31:0] STKSEQ_SP_POP16_WRAP = 32'h0000_fffe;
    localparam logic [31:0] STKSEQ_SEG64K_OFS = 32'h0001_0000;
    localparam logic [31:0] STKSEQ_SEG64K_LIMIT = 32'h0000_ffff;
    localparam logic [31:0] STKSEQ_ZERO = 32'h0000_0000;
    localparam logic [3:0] STKSEQ_SZ2 = 4'h2;
    localparam logic [3:0] STKSEQ_SZ4 = 4'h4;
    localparam logic [15:0] STKSEQ_HI_ZERO = 16'h0000;

    typedef enum logic [2:0] {
        STKSEQ_OP_SEL_PUSH = 3'h0,
        STKSEQ_OP_SEL_POP = 3'h1,
        STKSEQ_OP_POP_MEM = 3'h2,
        STKSEQ_OP_ERR_PUSH = 3'h3,
        STKSEQ_OP_FAR_CALL = 3'h4
    } stkseq_op_t;

    // One request from instruction and exception control
    typedef struct packed {
        stkseq_op_t op;
        logic opsz32;
        logic stack32;
        logic real_mode;
        logic [31:0] ea_extra;
        logic [31:0] data0;
        logic [31:0] data1;
    } stkseq_req_t;

    // One memory access toward the memory side
    typedef struct packed {
        logic write;
        logic [31:0] addr;
        logic [3:0] size;
        logic [31:0] wdata;
    } stkseq_mem_t;

    typedef enum logic [4:0] {
        STKSEQ_IDLE = 5'h01,
        STKSEQ_BRCHK = 5'h02,
        STKSEQ_ACC0 = 5'h04,
        STKSEQ_ACC1 = 5'h08,
        STKSEQ_DONE = 5'h10
    } stkseq_state_t;
endpackage

// [rtl/stkseq_limit_chk.sv]
// Purpose: Checks whether an access runs past the segment limit
// Assumes: Limit is the highest valid offset
// Notes: Flags also a fault on the upper half of a wide access
`timescale 1ns/100ps
`default_nettype none
module stkseq_limit_chk
    import stkseq_pkg::*;
(
    // Access
    input wire logic [31:0] addr,
    input wire logic [3:0] size,
    input wire logic [31:0] limit,
    input wire logic page_bad_hi,
    // Result
    output logic fault_any,
    output logic fault_hi
);
    wire logic [32:0] last_byte;
    wire logic [32:0] third_byte;
    wire logic wide;
    assign wide = (size == STKSEQ_SZ4);
    assign last_byte = {1'b0, addr} + {29'h0, size} - 33'h1;
    assign third_byte = {1'b0, addr} + {29'h0, STKSEQ_SZ2};
    assign fault_hi = wide && ((third_byte > {1'b0, limit}) || page_bad_hi);
    assign fault_any = ({1'b0, addr} > {1'b0, limit}) || (last_byte > {1'b0, limit}) || fault_hi;
endmodule
`default_nettype wire

// [tb/stkseq_mem_model.sv]
// Purpose: Memory side model answering stack accesses and branch checks
// Assumes: An access holds its request until mem_done
// Notes: Answer delay 1 or 2 cycles, picked by tick_r parity at the previous answer; read data toggles while idle
`timescale 1ns/100ps
`default_nettype none
module stkseq_mem_model
    import stkseq_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Access
    input wire logic mem_valid,
    input wire stkseq_mem_t mem_req,
    output logic mem_done,
    output logic [31:0] mem_rdata,
    // Branch check
    output logic br_chk_done
);
    logic [1:0] wait_r;
    logic [2:0] tick_r;
    wire fire = mem_valid && !mem_done && (wait_r == 2'h0);
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_r <= 2'h1;
            tick_r <= 3'h0;
            mem_done <= 1'b0;
            mem_rdata <= 32'h5a5a_a5a5;
            br_chk_done <= 1'b0;
        end else begin
            tick_r <= tick_r + 3'h1;
            mem_done <= fire;
            // Data valid only with mem_done, inverted otherwise
            mem_rdata <= fire ? {~mem_req.addr[15:0], mem_req.addr[15:0]} : ~mem_rdata;
            // Check result after each access, or now and then while idle
            br_chk_done <= mem_done || (!mem_valid && tick_r == 3'h0);
            if (fire) begin
                wait_r <= {1'b0, tick_r[0]};
            end else if (mem_valid && !mem_done) begin
                wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Purpose: Self-checking bench running both variants side by side
// Assumes: Variant 0 narrow push-first, variant 1 operand-sized branch-first
// Notes: Driver queues expected accesses and results; monitors compare
`timescale 1ns/100ps
`default_nettype none
module testbench
    import stkseq_pkg::*;
;
    typedef struct packed {
        logic [31:0] sp;
        logic spc;
        logic sf;
        logic bf;
        logic [15:0] pd;
        logic pdc;
    } stkseq_fin_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    stkseq_req_t rq = '0;
    logic [31:0] sp_in = 32'h0;
    logic [31:0] seg_limit = 32'hffff_ffff;
    logic pbh = 1'b0;
    logic lv = 1'b0;
    logic rv = 1'b0;
    logic [1:0] lax = 2'h0;
    wire [1:0] rdy, mv, md, bcd, dn, sf, bf;
    wire [31:0] spo [2];
    wire [31:0] rd [2];
    wire [31:0] pd [2];
    wire stkseq_mem_t mr [2];
    stkseq_mem_t aq [2][$];
    stkseq_fin_t fq [2][$];
    int n_errors = 0;
    int compares = 0;
    int nd = 0;
    logic [31:0] rng = 32'd85122;
    always #5 clock = ~clock;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic stkseq_mem_t acc(input logic w, input logic [31:0] a,
                                        input logic [3:0] s, input logic [31:0] d);
        return {w, a, s, d};
    endfunction
    for (genvar v = 0; v < 2; v++) begin : g_var
        stkseq_core #(.OPSZ_VARIANT(v == 1), .BRANCH_FIRST(v == 1)) u_stkseq_core (
            .clock(clock), .rst(rst), .req_valid(req_valid), .req(rq), .req_ready(rdy[v]),
            .sp_in(sp_in), .seg_limit(seg_limit), .stack_pointer(spo[v]),
            .br_chk_done(bcd[v]), .br_limit_viol(lv), .br_rights_viol(rv),
            .mem_valid(mv[v]), .mem_req(mr[v]), .mem_done(md[v]), .mem_rdata(rd[v]),
            .page_bad_hi(pbh), .done(dn[v]), .stack_fault(sf[v]), .branch_fault(bf[v]),
            .pop_data(pd[v]));
        stkseq_mem_model u_stkseq_mem_model (.clock(clock), .rst(rst), .mem_valid(mv[v]),
            .mem_req(mr[v]), .mem_done(md[v]), .mem_rdata(rd[v]), .br_chk_done(bcd[v]));
        always @(negedge clock) begin
            stkseq_mem_t e;
            stkseq_fin_t f;
            logic [31:0] m;
            if (!rst && mv[v] && md[v]) begin
                if (aq[v].size() > 0) begin
                    e = aq[v].pop_front();
                    m = (e.size == STKSEQ_SZ4) ? 32'hffff_ffff : 32'h0000_ffff;
                    if (!e.write) m = 32'h0;
                    check({27'h0, mr[v].write, mr[v].size}, {27'h0, e.write, e.size});
                    check(mr[v].addr, e.addr);
                    check(mr[v].wdata & m, e.wdata & m);
                end else if (!lax[v]) check(32'h1, 32'h0);
            end
            if (!rst && dn[v]) begin
                nd++;
                if (fq[v].size() > 0) begin
                    f = fq[v].pop_front();
                    check({30'h0, sf[v], bf[v]}, {30'h0, f.sf, f.bf});
                    if (f.spc) check(spo[v], f.sp);
                    if (f.pdc) check({16'h0, pd[v][15:0]}, {16'h0, f.pd});
                end else check(32'h1, 32'h0);
            end
        end
    end
    task automatic run(input stkseq_op_t op, input logic o32, input logic s32, input logic rm,
                       input logic [31:0] sp, input logic [31:0] lim, input logic pb,
                       input logic l, input logic r);
        logic [31:0] d0, d1, ea, nsp, sz;
        logic flt, bflt, lx, pdc;
        int t;
        int tgt;
        rng = xs(rng);
        d0 = rng;
        rng = xs(rng);
        d1 = rng;
        ea = {24'h0, rng[7:2], 2'h0};
        sz = o32 ? 32'h4 : 32'h2;
        bflt = (op == STKSEQ_OP_FAR_CALL) && (l || r);
        for (int v = 0; v < 2; v++) begin
            flt = 1'b0;
            lx = 1'b0;
            pdc = 1'b0;
            nsp = sp;
            case (op)
                STKSEQ_OP_SEL_PUSH: begin
                    nsp = sp - sz;
                    flt = v && o32 && (lim < nsp + 32'h3 || pb);
                    aq[v].push_back(acc(1'b1, nsp, v ? sz[3:0] : STKSEQ_SZ2,
                                        v ? {16'h0, d0[15:0]} : d0));
                end
                STKSEQ_OP_SEL_POP: begin
                    nsp = sp + sz;
                    pdc = 1'b1;
                    flt = v && o32 && (lim < sp + 32'h3 || pb);
                    aq[v].push_back(acc(1'b0, sp, v ? sz[3:0] : STKSEQ_SZ2, 32'h0));
                end
                STKSEQ_OP_ERR_PUSH: begin
                    nsp = sp - 32'h4;
                    aq[v].push_back(acc(1'b1, nsp, v ? STKSEQ_SZ4 : STKSEQ_SZ2,
                                        {16'h0, d0[15:0]}));
                end
                STKSEQ_OP_POP_MEM: begin
                    nsp = {sp[31:16], sp[15:0] + sz[15:0]};
                    flt = v && (rm || lim <= 32'h0000_ffff);
                    aq[v].push_back(acc(1'b0, sp, sz[3:0], 32'h0));
                    aq[v].push_back(acc(1'b1, (v ? 32'h0001_0000 : 32'h0) + ea, sz[3:0],
                                        {~sp[15:0], sp[15:0]}));
                end
                default: begin
                    nsp = bflt ? sp : sp - sz - sz;
                    lx = !v && bflt;
                    if (!(v && bflt)) aq[v].push_back(acc(1'b1, sp - sz, sz[3:0], d0));
                    if (!bflt) aq[v].push_back(acc(1'b1, sp - sz - sz, sz[3:0], d1));
                end
            endcase
            if (flt) aq[v].delete();
            lax[v] = lx || flt;
            fq[v].push_back({nsp, !flt, flt, bflt, sp[15:0], pdc && !flt});
        end
        tgt = nd + 2;
        @(posedge clock);
        #1;
        rq = {op, o32, s32, rm, ea, d0, d1};
        sp_in = sp;
        seg_limit = lim;
        pbh = pb;
        lv = l;
        rv = r;
        req_valid = 1'b1;
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        t = 0;
        while ((nd < tgt || rdy !== 2'h3) && t < 60) begin
            @(posedge clock);
            #1;
            t++;
        end
        if (t == 60) check(32'h1, 32'h0);
        for (int v = 0; v < 2; v++) begin
            if (lax[v]) aq[v].delete();
            check(32'(aq[v].size()), 32'h0);
        end
        $display("test %s finished", op.name());
    endtask
    initial begin
        logic [31:0] b;
        repeat (4) @(posedge clock);
        #1;
        rst = 1'b0;
        rng = xs(rng);
        b = 32'h0000_8000 + {20'h0, rng[11:4], 4'h0};
        run(STKSEQ_OP_SEL_PUSH, 1'b1, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_SEL_PUSH, 1'b0, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_SEL_POP, 1'b1, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_SEL_POP, 1'b0, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_ERR_PUSH, 1'b1, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_SEL_PUSH, 1'b1, 1'b1, 1'b0, b, b - 32'h3, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_SEL_POP, 1'b1, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b1, 1'b0, 1'b0);
        run(STKSEQ_OP_POP_MEM, 1'b1, 1'b0, 1'b0, 32'h0000_fffc, 32'h0001_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_POP_MEM, 1'b0, 1'b0, 1'b0, 32'h0000_fffe, 32'h0001_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_POP_MEM, 1'b1, 1'b0, 1'b1, 32'h0000_fffc, 32'h0001_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_POP_MEM, 1'b1, 1'b0, 1'b0, 32'h0000_fffc, 32'h0000_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_FAR_CALL, 1'b1, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b0, 1'b0, 1'b0);
        run(STKSEQ_OP_FAR_CALL, 1'b0, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b0, 1'b1, 1'b0);
        run(STKSEQ_OP_FAR_CALL, 1'b1, 1'b1, 1'b0, b, 32'hffff_ffff, 1'b0, 1'b0, 1'b1);
        wrap_up();
    end
    initial begin
        #50000;
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
